// ### rtl/sclk_pkg.sv
// sclk_pkg: constants for the system clock source select and pll output divider
// assumes an apb slave with 32-bit data and byte addresses of four times the register index
`default_nettype none
package sclk_pkg;
  // ==========================================================
  // register map
  localparam logic [15:0] SCLK_IDX_SRC_CFG = 16'h1c1f;
  localparam logic [15:0] SCLK_IDX_DIV_CTL = 16'h1c23;
  localparam logic [31:0] SCLK_ADDR_SRC_CFG = {14'h0000, SCLK_IDX_SRC_CFG, 2'h0};
  localparam logic [31:0] SCLK_ADDR_DIV_CTL = {14'h0000, SCLK_IDX_DIV_CTL, 2'h0};
  // ==========================================================
  // clock_source_config fields
  localparam int SCLK_MODE_SEL_BIT  = 0;
  localparam int SCLK_STRAP_BIT     = 2;
  localparam int SCLK_STATUS_LSB    = 4;
  // ==========================================================
  // pll_output_divider_ctrl fields
  localparam int SCLK_RATIO_LSB     = 0;
  localparam int SCLK_DIV_EN_BIT    = 9;
  // ==========================================================
  // reset values
  localparam logic       SCLK_RST_MODE_SEL = 1'b0;
  localparam logic       SCLK_RST_DIV_EN   = 1'b0;
  localparam logic [7:0] SCLK_RST_RATIO    = 8'h00;
  // ==========================================================
  // source status codes: bit 1 is the strap, bit 0 is pll mode
  localparam logic [1:0] SCLK_ST_BYP_RTC = 2'h0;
  localparam logic [1:0] SCLK_ST_PLL_RTC = 2'h1;
  localparam logic [1:0] SCLK_ST_BYP_EXT = 2'h2;
  localparam logic [1:0] SCLK_ST_PLL_EXT = 2'h3;
  // ==========================================================
  // mode of the system clock
  typedef enum logic {
    SCLK_BYPASS = 1'b0,
    SCLK_PLL    = 1'b1
  } sclk_mode_e;
endpackage
`default_nettype wire

// ### rtl/sclk_source_select.sv
// sclk_source_select: system clock mode switch, pll output divider, apb registers
// assumes clock sources and strap arrive as pins sampled on pclk; system clock is a tick stream
//
// Overview of operation
// (R1) divider enable 1 divides, 0 bypasses divider
// (R2) pll output divided by ratio plus one
// (R3) read-only status shows actual clock source
// (R4) status codes: 0 rtc, 1 pll-rtc, 2 ext, 3 pll-ext
// (R5) refuse pll mode while pll powered down
// (R6) software never powers down pll in pll mode
// (R7) strap status bit follows input select pin
// (R8) select bit: 0 bypass, 1 requests pll
// (R9) bypass uses strap-chosen input; pll uses generator
// (R10) software writes zero to reserved bits 3, 1
// (R11) power-down 1 means pll off; gates switch
// (R12) status changes only after source changed
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module sclk_source_select
  import sclk_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rtc_osc_in,
  input  wire logic        external_clock_input,
  input  wire logic        pll_clk_in,
  input  wire logic        input_select_strap,
  input  wire logic        pll_power_down,
  output logic             system_clock_tick,
  output logic [1:0]       sys_clk_source_status
);
  // ==========================================================
  // pin synchronisers: stage 1 feeds stage 2 only
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic [3:0] last_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
      last_q <= 4'h0;
    end else begin
      meta_q <= {input_select_strap, pll_clk_in, external_clock_input, rtc_osc_in};
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  logic rtc_rise;
  logic ext_rise;
  logic pll_rise;
  logic strap_s;
  assign rtc_rise = sync_q[0] & ~last_q[0];
  assign ext_rise = sync_q[1] & ~last_q[1];
  assign pll_rise = sync_q[2] & ~last_q[2];
  assign strap_s  = sync_q[3];

  // ==========================================================
  // apb register access
  logic       wr_en;
  logic       hit_cfg;
  logic       hit_div;
  logic       mode_req_q;
  logic       mode_req_d;
  logic       div_en_q;
  logic       div_en_d;
  logic [7:0] ratio_q;
  logic [7:0] ratio_d;

  assign hit_cfg = (paddr == SCLK_ADDR_SRC_CFG);
  assign hit_div = (paddr == SCLK_ADDR_DIV_CTL);
  assign wr_en   = psel & penable & pwrite;
  // zero wait states; an unmapped address answers with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(hit_cfg | hit_div);

  always_comb begin
    mode_req_d = mode_req_q;
    div_en_d   = div_en_q;
    ratio_d    = ratio_q;
    if (wr_en && hit_cfg) begin
      // only the select bit is stored; reserved positions are dropped
      mode_req_d = pwdata[SCLK_MODE_SEL_BIT]; // R8 R10
    end
    if (wr_en && hit_div) begin
      div_en_d = pwdata[SCLK_DIV_EN_BIT];
      ratio_d  = pwdata[SCLK_RATIO_LSB +: 8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_req_q <= SCLK_RST_MODE_SEL;
      div_en_q   <= SCLK_RST_DIV_EN;
      ratio_q    <= SCLK_RST_RATIO;
    end else begin
      mode_req_q <= mode_req_d;
      div_en_q   <= div_en_d;
      ratio_q    <= ratio_d;
    end
  end

  // ==========================================================
  // mode switch with power-down interlock
  sclk_mode_e mode_q;
  sclk_mode_e mode_d;
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      SCLK_BYPASS: begin
        // a powered-down pll would leave the system without a clock
        if (mode_req_q && !pll_power_down) begin // R5 R11
          mode_d = SCLK_PLL;
        end
      end
      SCLK_PLL: begin
        // no guard against power-down here: software must avoid it
        if (!mode_req_q) begin // R8 R6
          mode_d = SCLK_BYPASS;
        end
      end
    endcase
  end

  // ==========================================================
  // output divider and source multiplexer
  logic [7:0] div_cnt_q;
  logic [7:0] div_cnt_d;
  logic       div_tick;
  logic       src_tick;
  logic       tick_q;
  logic       tick_d;
  logic [1:0] status_q;
  logic [1:0] status_d;

  always_comb begin
    div_cnt_d = div_cnt_q;
    div_tick  = 1'b0;
    if (pll_rise) begin
      if (!div_en_q) begin
        div_tick  = 1'b1; // R1
        div_cnt_d = 8'h00;
      end else if (div_cnt_q >= ratio_q) begin
        // a ratio lowered mid-count ends the period at once instead of wrapping
        div_tick  = 1'b1; // R2
        div_cnt_d = 8'h00;
      end else begin
        div_cnt_d = div_cnt_q + 8'h01;
      end
    end
  end

  always_comb begin
    if (mode_q == SCLK_PLL) begin
      src_tick = div_tick; // R9
    end else begin
      src_tick = strap_s ? ext_rise : rtc_rise; // R9
    end
    tick_d   = src_tick;
    // status is taken from the mode in force, not from the request
    status_d = {strap_s, mode_q == SCLK_PLL}; // R3 R4 R12
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q    <= SCLK_BYPASS;
      div_cnt_q <= 8'h00;
      tick_q    <= 1'b0;
      status_q  <= SCLK_ST_BYP_RTC;
    end else begin
      mode_q    <= mode_d;
      div_cnt_q <= div_cnt_d;
      tick_q    <= tick_d;
      status_q  <= status_d;
    end
  end

  assign system_clock_tick     = tick_q;
  assign sys_clk_source_status = status_q;

  // ==========================================================
  // read data, registered on the setup cycle
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = rdata_q;
    if (psel && !penable && !pwrite) begin
      rdata_d = 32'h0000_0000;
      if (hit_cfg) begin
        rdata_d[SCLK_MODE_SEL_BIT]        = mode_req_q;
        rdata_d[SCLK_STRAP_BIT]           = strap_s; // R7
        rdata_d[SCLK_STATUS_LSB +: 2]     = status_q; // R3
      end else if (hit_div) begin
        rdata_d[SCLK_DIV_EN_BIT]          = div_en_q;
        rdata_d[SCLK_RATIO_LSB +: 8]      = ratio_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign prdata = rdata_q;

  // ==========================================================
  // checks
  chk_refuse_pll_down: assert property (@(posedge pclk) disable iff (!presetn) // R5
    (mode_q == SCLK_BYPASS && pll_power_down) |=> (mode_q == SCLK_BYPASS))
    else $error("pll mode entered while pll powered down");

  chk_grant_pll_mode: assert property (@(posedge pclk) disable iff (!presetn) // R8
    (mode_q == SCLK_BYPASS && mode_req_q && !pll_power_down) |=> (mode_q == SCLK_PLL))
    else $error("pll mode request not granted");

  chk_bypass_request: assert property (@(posedge pclk) disable iff (!presetn) // R8
    (!mode_req_q) |=> (mode_q == SCLK_BYPASS) ##1 (status_q[0] == 1'b0))
    else $error("bypass request not honoured");

  chk_status_follows: assert property (@(posedge pclk) disable iff (!presetn) // R12
    $rose(mode_q == SCLK_PLL) |-> (status_q[0] == 1'b0) ##1 (status_q[0] == 1'b1))
    else $error("status changed before the source");

  chk_status_strap: assert property (@(posedge pclk) disable iff (!presetn) // R4
    1'b1 |=> (status_q == {$past(strap_s), $past(mode_q == SCLK_PLL)}))
    else $error("status code does not match source");

  chk_strap_readback: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (psel && !penable && !pwrite && hit_cfg) |=> (prdata[SCLK_STRAP_BIT] == $past(strap_s)))
    else $error("strap status bit wrong");

  chk_div_ratio_tick: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (mode_q == SCLK_PLL && pll_rise && div_en_q && div_cnt_q < ratio_q) |=> !system_clock_tick)
    else $error("divider ticked before its ratio");

  chk_div_bypassed: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (mode_q == SCLK_PLL && pll_rise && !div_en_q) |=> system_clock_tick)
    else $error("undivided pll edge lost");

  chk_bypass_source: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (mode_q == SCLK_BYPASS && !(strap_s ? ext_rise : rtc_rise)) |=> !system_clock_tick)
    else $error("bypass tick from wrong source");

  chk_ext_bypass_tick: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (mode_q == SCLK_BYPASS && strap_s && ext_rise) |=> system_clock_tick)
    else $error("external input edge lost in bypass");

  chk_rtc_bypass_tick: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (mode_q == SCLK_BYPASS && !strap_s && rtc_rise) |=> system_clock_tick)
    else $error("rtc edge lost in bypass");

  chk_div_full_count: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (mode_q == SCLK_PLL && pll_rise && div_en_q && div_cnt_q >= ratio_q) |=> system_clock_tick)
    else $error("divider missed its ratio edge");

  chk_status_refused: assert property (@(posedge pclk) disable iff (!presetn) // R12
    (mode_q == SCLK_BYPASS && pll_power_down) |-> ##2 (status_q[0] == 1'b0))
    else $error("status left bypass while pll powered down");

  chk_pll_kept: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (mode_q == SCLK_PLL && mode_req_q) |=> (mode_q == SCLK_PLL))
    else $error("pll mode left without a bypass request");

  chk_cfg_write_lands: assert property (@(posedge pclk) disable iff (!presetn) // R8
    (psel && penable && pwrite && hit_cfg) |=> (mode_req_q == $past(pwdata[SCLK_MODE_SEL_BIT])))
    else $error("mode select write lost");

  chk_div_write_lands: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (psel && penable && pwrite && hit_div) |=>
      (ratio_q == $past(pwdata[SCLK_RATIO_LSB +: 8]) && div_en_q == $past(pwdata[SCLK_DIV_EN_BIT])))
    else $error("divider control write lost");

  chk_div_readback: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (psel && !penable && !pwrite && hit_div) |=>
      (prdata[SCLK_DIV_EN_BIT] == $past(div_en_q) && prdata[SCLK_RATIO_LSB +: 8] == $past(ratio_q)))
    else $error("divider control read back wrong");

  chk_status_readback: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (psel && !penable && !pwrite && hit_cfg) |=> (prdata[SCLK_STATUS_LSB +: 2] == $past(status_q)))
    else $error("source status read back wrong");

  chk_unmapped_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && !hit_cfg && !hit_div) |=> (prdata == 32'h0000_0000))
    else $error("unmapped read returned data");

  cov_pll_entered: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(mode_q == SCLK_PLL));
  cov_pll_refused: cover property (@(posedge pclk) disable iff (!presetn)
    mode_req_q && pll_power_down && mode_q == SCLK_BYPASS);
  cov_divided_tick: cover property (@(posedge pclk) disable iff (!presetn)
    mode_q == SCLK_PLL && div_en_q && ratio_q != 8'h00 && div_tick);
  cov_ext_bypass: cover property (@(posedge pclk) disable iff (!presetn)
    status_q == SCLK_ST_BYP_EXT && system_clock_tick);
  cov_pll_left: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(mode_q == SCLK_PLL));
endmodule
`default_nettype wire

// ### tb/sclk_src_model.sv
// sclk_src_model: free-running oscillator levels for rtc, external input and pll output
// assumes pclk is at least four times faster than every source (each level held >= 2 pclk)
`timescale 1ns/100ps
`default_nettype none
module sclk_src_model #(
  parameter int RTC_HALF = 5,
  parameter int EXT_HALF = 4,
  parameter int PLL_HALF = 3
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      rtc_clk,
  output logic      ext_clk,
  output logic      pll_clk
);
  // ==========================================================
  // oscillators run free; only their half periods differ
  int rc, ec, pc;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc      <= 0;
      ec      <= 0;
      pc      <= 0;
      rtc_clk <= 1'b0;
      ext_clk <= 1'b0;
      pll_clk <= 1'b0;
    end else begin
      rc <= (rc == RTC_HALF - 1) ? 0 : rc + 1;
      ec <= (ec == EXT_HALF - 1) ? 0 : ec + 1;
      pc <= (pc == PLL_HALF - 1) ? 0 : pc + 1;
      if (rc == RTC_HALF - 1) rtc_clk <= ~rtc_clk;
      if (ec == EXT_HALF - 1) ext_clk <= ~ext_clk;
      if (pc == PLL_HALF - 1) pll_clk <= ~pll_clk;
    end
  end
endmodule
`default_nettype wire

// ### tb/sclk_source_select_bench.sv
// sclk_source_select_bench: apb register tests and system clock tick spacing
// assumes the design answers apb with pready and sources come from sclk_src_model
`timescale 1ns/100ps
`default_nettype none
module sclk_source_select_bench;
  import sclk_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, strap, pwr_dn, pready, pslverr, tick;
  logic        rtc, ext, pll;
  logic [31:0] paddr, pwdata, prdata;
  logic [1:0]  status;
  int          fails, check_count;
  logic [31:0] r;
  logic        e;

  sclk_src_model #(.RTC_HALF(5), .EXT_HALF(4), .PLL_HALF(3)) model (.pclk(pclk), .presetn(presetn),
    .rtc_clk(rtc), .ext_clk(ext), .pll_clk(pll));
  sclk_source_select dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rtc_osc_in(rtc), .external_clock_input(ext), .pll_clk_in(pll),
    .input_select_strap(strap), .pll_power_down(pwr_dn), .system_clock_tick(tick),
    .sys_clk_source_status(status));

  // ==========================================================
  // clock, verdict, watchdog
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic test_done();
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    fails++;
    test_done();
  endtask
  initial begin
    #1ms;
    hang();
  end

  // ==========================================================
  // apb master: request held until pready is seen high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(r, exp);
  endtask
  // second full gap between ticks (ending on the third tick), so a stale divider count has flushed out
  task automatic gap(input int exp);
    int n, k;
    for (k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (tick !== 1'b1 && n < 4000);
      if (n >= 4000) hang();
    end
    cmp(n, exp);
  endtask

  // ==========================================================
  // main sequence; pin changes wait 6 edges (2 sync + 2 mode, plus margin)
  initial begin
    fails = 0;
    check_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    strap = 1'b0;
    pwr_dn = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(SCLK_ADDR_SRC_CFG, 32'h0);
    rd(SCLK_ADDR_DIV_CTL, 32'h0);
    rd(32'h0, 32'h0);
    cmp({31'h0, e}, 32'h1);
    gap(10);
    apb(1'b1, SCLK_ADDR_SRC_CFG, 32'h1);
    repeat (6) @(posedge pclk);
    rd(SCLK_ADDR_SRC_CFG, 32'h1);
    cmp({30'h0, status}, {30'h0, SCLK_ST_BYP_RTC});
    gap(10);
    pwr_dn <= 1'b0;
    repeat (6) @(posedge pclk);
    rd(SCLK_ADDR_SRC_CFG, 32'h11);
    cmp({30'h0, status}, {30'h0, SCLK_ST_PLL_RTC});
    gap(6);
    apb(1'b1, SCLK_ADDR_DIV_CTL, 32'h202);
    gap(18);
    apb(1'b1, SCLK_ADDR_DIV_CTL, 32'h200);
    gap(6);
    apb(1'b1, SCLK_ADDR_DIV_CTL, 32'h2ff);
    gap(1536);
    rd(SCLK_ADDR_DIV_CTL, 32'h2ff);
    apb(1'b1, SCLK_ADDR_DIV_CTL, 32'h5);
    gap(6);
    apb(1'b1, SCLK_ADDR_SRC_CFG, 32'h0);
    strap <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(SCLK_ADDR_SRC_CFG, 32'h24);
    cmp({30'h0, status}, {30'h0, SCLK_ST_BYP_EXT});
    gap(8);
    apb(1'b1, SCLK_ADDR_SRC_CFG, 32'h31);
    repeat (6) @(posedge pclk);
    rd(SCLK_ADDR_SRC_CFG, 32'h35);
    cmp({30'h0, status}, {30'h0, SCLK_ST_PLL_EXT});
    // power goes down only once pll mode has been left
    apb(1'b1, SCLK_ADDR_SRC_CFG, 32'h0);
    repeat (4) @(posedge pclk);
    pwr_dn <= 1'b1;
    apb(1'b1, SCLK_ADDR_SRC_CFG, 32'h1);
    repeat (6) @(posedge pclk);
    rd(SCLK_ADDR_SRC_CFG, 32'h25);
    cmp({30'h0, status}, {30'h0, SCLK_ST_BYP_EXT});
    apb(1'b1, 32'h4, 32'h1);
    cmp({31'h0, e}, 32'h1);
    test_done();
  end
endmodule
`default_nettype wire
